// ===== verilog/srsu_shift_unit.v
// Execute-stage datapath for packed SIMD right shifts
`timescale 1ns/1ps
`include "srsu_consts.vh"
module srsu_shift_unit #(
  parameter DW = 64,
  parameter IW = 32
) (
  // Clock, reset, enable
  input wire core_clk_in,
  input wire reset_n_in,
  input wire clk_en_in,
  // Issue from decode
  input wire issue_valid_in,
  input wire [IW-1:0] instr_in,
  input wire ext_enable_in,
  // Operands from the general register file
  input wire [DW-1:0] source_register_in,
  input wire [DW-1:0] shift_amount_register_in,
  // Write-back
  output reg result_valid_out,
  output reg [DW-1:0] result_out,
  // Exceptions
  output reg reserved_instr_exc_out,
  output reg ext_disabled_exc_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  // Maps instruction fields to an operation code; used for issue and hit
  function [2:0] srsu_decode;
    input [IW-1:0] ins;
    reg [5:0] major;
    reg [4:0] sec;
    reg [5:0] func;
    begin
      major = ins[`SRSU_MAJOR_HI:`SRSU_MAJOR_LO];
      sec = ins[`SRSU_SEC_HI:`SRSU_SEC_LO];
      func = ins[`SRSU_FUNC_HI:`SRSU_FUNC_LO];
      srsu_decode = `SRSU_OP_NONE;
      if (major == `SRSU_EXT_MAJOR) begin
        if (sec == `SRSU_SEC_BYTE_IMM &&
            ins[`SRSU_BYTE_ZERO_HI:`SRSU_BYTE_ZERO_LO] == 2'h0) begin
          if (func == `SRSU_FUNC_WIDE) begin
            srsu_decode = `SRSU_OP_LI_OB;
          end else if (func == `SRSU_FUNC_NARROW) begin
            srsu_decode = `SRSU_OP_LI_QB;
          end
        end else if (sec == `SRSU_SEC_HALF_IMM && !ins[`SRSU_IMM_BIT25]) begin
          if (func == `SRSU_FUNC_WIDE) begin
            srsu_decode = `SRSU_OP_LI_QH;
          end else if (func == `SRSU_FUNC_NARROW) begin
            srsu_decode = `SRSU_OP_LI_PH;
          end
        end else if (sec == `SRSU_SEC_ARITH_W_RND && func == `SRSU_FUNC_NARROW) begin
          srsu_decode = `SRSU_OP_AV_W_RND;
        end else if (sec == `SRSU_SEC_ARITH_QH && func == `SRSU_FUNC_WIDE) begin
          srsu_decode = `SRSU_OP_AV_QH;
        end else if (sec == `SRSU_SEC_ARITH_QH_RND && func == `SRSU_FUNC_WIDE) begin
          srsu_decode = `SRSU_OP_AV_QH_RND;
        end
      end
    end
  endfunction

  wire [2:0] op;
  assign op = srsu_decode(instr_in);

  // Only the extension major opcode is this unit's to reject
  wire ours;
  assign ours = (instr_in[`SRSU_MAJOR_HI:`SRSU_MAJOR_LO] == `SRSU_EXT_MAJOR);

  ////////////////////////////////////////////////////////////////////////////
  // Shift amounts

  wire [`SRSU_HALF_AMT_W-1:0] half_var_amt;
  wire [`SRSU_WORD_AMT_W-1:0] word_var_amt;
  wire [`SRSU_BYTE_AMT_W-1:0] byte_imm_amt;
  wire [`SRSU_HALF_AMT_W-1:0] half_imm_amt;
  assign half_var_amt = shift_amount_register_in[`SRSU_HALF_AMT_W-1:0];
  assign word_var_amt = shift_amount_register_in[`SRSU_WORD_AMT_W-1:0];
  assign byte_imm_amt = instr_in[`SRSU_BYTE_IMM_HI:`SRSU_BYTE_IMM_LO];
  assign half_imm_amt = instr_in[`SRSU_HALF_IMM_HI:`SRSU_HALF_IMM_LO];

  wire rnd_qh;
  assign rnd_qh = (op == `SRSU_OP_AV_QH_RND);

  ////////////////////////////////////////////////////////////////////////////
  // Lanes

  wire [DW-1:0] arith_qh;
  wire [DW-1:0] logic_h;
  wire [DW-1:0] logic_b;
  wire [31:0] arith_w;

  genvar g;
  generate
    // Four halfword lanes, arithmetic and logical
    for (g = 0; g < DW/16; g = g + 1) begin : g_half
      srsu_arith_lane #(.W(16), .SW(`SRSU_HALF_AMT_W)) u_arith (
        .value_in(source_register_in[16*g +: 16]),
        .amount_in(half_var_amt),
        .round_in(rnd_qh),
        .result_out(arith_qh[16*g +: 16])
      );
      srsu_logic_lane #(.W(16), .SW(`SRSU_HALF_AMT_W)) u_logic (
        .value_in(source_register_in[16*g +: 16]),
        .amount_in(half_imm_amt),
        .result_out(logic_h[16*g +: 16])
      );
    end
    // Eight byte lanes, zero-filling
    for (g = 0; g < DW/8; g = g + 1) begin : g_byte
      srsu_logic_lane #(.W(8), .SW(`SRSU_BYTE_AMT_W)) u_logic (
        .value_in(source_register_in[8*g +: 8]),
        .amount_in(byte_imm_amt),
        .result_out(logic_b[8*g +: 8])
      );
    end
  endgenerate

  // Word lane always rounds
  srsu_arith_lane #(.W(32), .SW(`SRSU_WORD_AMT_W)) u_word (
    .value_in(source_register_in[31:0]),
    .amount_in(word_var_amt),
    .round_in(1'b1),
    .result_out(arith_w)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Operation classes
  // Every lane is computed each cycle; the classes below only pick results.
  // Trading area for timing: no shifter is shared between lane widths,
  // so the select is the only logic that grows with the variant count.

  // Forms that copy one sign bit over the upper word; read by every high slot
  function srsu_upper_fill;
    input [2:0] code;
    begin
      case (code)
        `SRSU_OP_AV_W_RND: srsu_upper_fill = 1'b1;
        `SRSU_OP_LI_QB: srsu_upper_fill = 1'b1;
        `SRSU_OP_LI_PH: srsu_upper_fill = 1'b1;
        default: srsu_upper_fill = 1'b0;
      endcase
    end
  endfunction

  // Quad-halfword arithmetic, plain or rounding
  wire cls_arith_qh;
  assign cls_arith_qh = (op == `SRSU_OP_AV_QH) || (op == `SRSU_OP_AV_QH_RND);

  // Rounding word form
  wire cls_word;
  assign cls_word = (op == `SRSU_OP_AV_W_RND);

  // Octal-byte logical form
  wire cls_octal_byte;
  assign cls_octal_byte = (op == `SRSU_OP_LI_OB);

  // Quad-byte logical form
  wire cls_quad_byte;
  assign cls_quad_byte = (op == `SRSU_OP_LI_QB);

  // Pair-halfword logical form
  wire cls_pair_half;
  assign cls_pair_half = (op == `SRSU_OP_LI_PH);

  // Quad-halfword logical form
  wire cls_quad_half;
  assign cls_quad_half = (op == `SRSU_OP_LI_QH);

  // Any form this unit executes
  wire cls_known;
  assign cls_known = (op != `SRSU_OP_NONE);

  // Sign bit copied upward; zero when the form fills nothing
  // Taken from the result, not the source, so a shifted-out sign is lost
  reg fill_bit;
  always @* begin
    fill_bit = 1'b0;
    if (cls_word) begin
      fill_bit = arith_w[`SRSU_WORD_W-1];
    end else if (cls_quad_byte) begin
      fill_bit = logic_b[`SRSU_WORD_W-1];
    end else if (cls_pair_half) begin
      fill_bit = logic_h[`SRSU_WORD_W-1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result slots
  // Built one halfword at a time so each slot's mux stays narrow;
  // the low and high words differ only in where their bits come from.
  // Unknown forms leave zeros; valid stays low for them anyway.

  wire [DW-1:0] next_result;

  genvar slot;
  generate
    for (slot = 0; slot < DW/`SRSU_HALF_W; slot = slot + 1) begin : g_slot
      if (slot < `SRSU_WORD_W/`SRSU_HALF_W) begin : g_low
        // Low word: every known form writes lane data here
        reg [`SRSU_HALF_W-1:0] next_slot;
        always @* begin
          next_slot = {`SRSU_HALF_W{1'b0}};
          if (cls_arith_qh) begin
            next_slot = arith_qh[`SRSU_HALF_W*slot +: `SRSU_HALF_W];
          end else if (cls_word) begin
            next_slot = arith_w[`SRSU_HALF_W*slot +: `SRSU_HALF_W];
          end else if (cls_octal_byte || cls_quad_byte) begin
            next_slot = logic_b[`SRSU_HALF_W*slot +: `SRSU_HALF_W];
          end else if (cls_pair_half || cls_quad_half) begin
            next_slot = logic_h[`SRSU_HALF_W*slot +: `SRSU_HALF_W];
          end
        end
        assign next_result[`SRSU_HALF_W*slot +: `SRSU_HALF_W] = next_slot;
      end else begin : g_high
        // High word: full-width forms keep lanes, narrow forms copy the sign
        reg [`SRSU_HALF_W-1:0] next_slot;
        always @* begin
          next_slot = {`SRSU_HALF_W{1'b0}};
          if (srsu_upper_fill(op)) begin
            next_slot = {`SRSU_HALF_W{fill_bit}};
          end else if (cls_arith_qh) begin
            next_slot = arith_qh[`SRSU_HALF_W*slot +: `SRSU_HALF_W];
          end else if (cls_octal_byte) begin
            next_slot = logic_b[`SRSU_HALF_W*slot +: `SRSU_HALF_W];
          end else if (cls_quad_half) begin
            next_slot = logic_h[`SRSU_HALF_W*slot +: `SRSU_HALF_W];
          end
        end
        assign next_result[`SRSU_HALF_W*slot +: `SRSU_HALF_W] = next_slot;
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Issue qualification
  // Foreign major opcodes pass silently: another unit owns them.
  // Operand data never enters these terms, so no value can fault.

  // An issue belongs here only under the extension major opcode
  wire issue_ours;
  assign issue_ours = issue_valid_in && ours;

  // Exactly one of the three flags per owned issue
  reg next_valid;
  reg next_rsv_exc;
  reg next_dis_exc;
  always @* begin
    next_valid = 1'b0;
    next_rsv_exc = 1'b0;
    next_dis_exc = 1'b0;
    if (issue_ours) begin
      if (!ext_enable_in) begin
        next_dis_exc = 1'b1;
      end else if (cls_known) begin
        next_valid = 1'b1;
      end else begin
        next_rsv_exc = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Execute register
  // All four outputs share one enable; a low enable freezes them together.
  // Each sits in its own process so one output's reset cannot mask another.

  // Write-back valid, one pulse per accepted issue
  always @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      result_valid_out <= 1'b0;
    end else if (clk_en_in) begin
      result_valid_out <= next_valid;
    end
  end

  // Result loads every enabled edge; readers qualify it with valid
  always @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      result_out <= {DW{1'b0}};
    end else if (clk_en_in) begin
      result_out <= next_result;
    end
  end

  // Reserved-instruction flag, opcode-driven only
  always @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reserved_instr_exc_out <= 1'b0;
    end else if (clk_en_in) begin
      reserved_instr_exc_out <= next_rsv_exc;
    end
  end

  // Extension-disabled flag, wins over decode
  always @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ext_disabled_exc_out <= 1'b0;
    end else if (clk_en_in) begin
      ext_disabled_exc_out <= next_dis_exc;
    end
  end

endmodule

// ===== pkg/srsu_consts.vh
// Opcode fields, encodings and widths for the packed right-shift unit
`ifndef SRSU_CONSTS_VH
`define SRSU_CONSTS_VH

`define SRSU_MAJOR_HI 31
`define SRSU_MAJOR_LO 26
`define SRSU_EXT_MAJOR 6'h1f
`define SRSU_SEC_HI 10
`define SRSU_SEC_LO 6
`define SRSU_FUNC_HI 5
`define SRSU_FUNC_LO 0
`define SRSU_FUNC_WIDE 6'h17
`define SRSU_FUNC_NARROW 6'h13
`define SRSU_SEC_BYTE_IMM 5'h01
`define SRSU_SEC_HALF_IMM 5'h19
`define SRSU_SEC_ARITH_QH 5'h17
`define SRSU_SEC_ARITH_QH_RND 5'h1f
`define SRSU_SEC_ARITH_W_RND 5'h17
`define SRSU_IMM_BIT25 25
`define SRSU_BYTE_ZERO_HI 25
`define SRSU_BYTE_ZERO_LO 24
`define SRSU_BYTE_IMM_HI 23
`define SRSU_BYTE_IMM_LO 21
`define SRSU_HALF_IMM_HI 24
`define SRSU_HALF_IMM_LO 21

`define SRSU_OP_NONE 3'h0
`define SRSU_OP_AV_QH 3'h1
`define SRSU_OP_AV_QH_RND 3'h2
`define SRSU_OP_AV_W_RND 3'h3
`define SRSU_OP_LI_OB 3'h4
`define SRSU_OP_LI_QB 3'h5
`define SRSU_OP_LI_PH 3'h6
`define SRSU_OP_LI_QH 3'h7

`define SRSU_HALF_AMT_W 4
`define SRSU_WORD_AMT_W 5
`define SRSU_BYTE_AMT_W 3

`define SRSU_HALF_W 16
`define SRSU_WORD_W 32

`endif

// ===== verilog/srsu_arith_lane.v
// One arithmetic right-shift lane with optional rounding
`timescale 1ns/1ps
module srsu_arith_lane #(
  parameter W = 16,
  parameter SW = 4
) (
  // Operand
  input wire [W-1:0] value_in,
  input wire [SW-1:0] amount_in,
  input wire round_in,
  // Result
  output wire [W-1:0] result_out
);
  // Shift one less, keeping the first discarded bit in the LSB
  wire [W:0] ext;
  wire [W:0] pre;
  wire [W:0] sum;
  assign ext = {value_in, 1'b0};
  assign pre = $signed(ext) >>> amount_in;
  // Adding one at the discarded position; drop the guard bit
  assign sum = pre + {{W{1'b0}}, (round_in && (amount_in != {SW{1'b0}}))};
  assign result_out = sum[W:1];
endmodule

// ===== verilog/srsu_logic_lane.v
// One logical (zero-fill) right-shift lane
`timescale 1ns/1ps
module srsu_logic_lane #(
  parameter W = 8,
  parameter SW = 3
) (
  // Operand
  input wire [W-1:0] value_in,
  input wire [SW-1:0] amount_in,
  // Result
  output wire [W-1:0] result_out
);
  // Amount zero passes the lane unchanged by construction
  assign result_out = value_in >> amount_in;
endmodule

// ===== verification/srsu_props.sv
// Port-level checker for the packed right-shift unit
`timescale 1ns/1ps
`include "srsu_consts.vh"
module srsu_props (
  // Clock, reset and issue side
  input wire core_clk_in,
  input wire reset_n_in,
  input wire clk_en_in,
  input wire issue_valid_in,
  input wire [31:0] instr_in,
  input wire ext_enable_in,
  input wire [63:0] source_register_in,
  input wire [63:0] shift_amount_register_in,
  // Write-back and exceptions
  input wire result_valid_out,
  input wire [63:0] result_out,
  input wire reserved_instr_exc_out,
  input wire ext_disabled_exc_out
);
  // Own decode, so a slip in the unit's decoder cannot hide
  wire go = issue_valid_in && clk_en_in && instr_in[31:26] == `SRSU_EXT_MAJOR;
  wire ok = go && ext_enable_in;
  wire [4:0] sec = instr_in[10:6];
  wire nar = instr_in[5:0] == 6'h13;
  wire fok = nar || instr_in[5:0] == 6'h17;
  wire known = fok && (sec == 5'h01 && !instr_in[25:24] || sec == 5'h19 && !instr_in[25]
    || sec == 5'h17) || sec == 5'h1f && !nar && fok;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);
  ////////////////////////////////////////////////////////////////////////////////
  chk_res_issue: assert property (
    ok && known |=> result_valid_out && !reserved_instr_exc_out) else $error("no result");
  chk_rsv_exc: assert property (
    ok && !known |=> reserved_instr_exc_out && !result_valid_out) else $error("no reserved flag");
  chk_ext_off: assert property (
    go && !ext_enable_in |=> ext_disabled_exc_out && !result_valid_out) else $error("no off flag");
  chk_idle_quiet: assert property (
    clk_en_in && !go |=> !result_valid_out && !reserved_instr_exc_out
    && !ext_disabled_exc_out) else $error("spurious");
  chk_gate_hold: assert property (
    !clk_en_in |=> $stable(result_out) && $stable(result_valid_out)) else $error("gated change");
  chk_narrow_sign: assert property (
    ok && known && nar |=> result_out[63:32] == {32{result_out[31]}}) else $error("upper bits");
  chk_byte_zero: assert property (
    ok && known && !nar && sec == 5'h01 && instr_in[23:21] == 3'h0
    |=> result_out == $past(source_register_in)) else $error("zero shift changed bytes");
  chk_half_mask: assert property (
    ok && !nar && sec == 5'h17 && shift_amount_register_in[3:0] == 4'h0
    |=> result_out == $past(source_register_in)) else $error("high amount bits used");
endmodule
bind srsu_shift_unit srsu_props srsu_props_i (.core_clk_in, .reset_n_in, .clk_en_in,
  .issue_valid_in, .instr_in, .ext_enable_in, .source_register_in, .shift_amount_register_in,
  .result_valid_out, .result_out, .reserved_instr_exc_out, .ext_disabled_exc_out);

// ===== verification/srsu_core_model.sv
// Register-file model that feeds operands to the shift unit
`timescale 1ns/1ps
module srsu_core_model (
  // Clock and write port
  input wire core_clk_in,
  input wire wr_en_in,
  input wire [4:0] wr_idx_in,
  input wire [63:0] wr_data_in,
  // Reads addressed by the instruction fields
  input wire [31:0] instr_in,
  output wire [63:0] source_out,
  output wire [63:0] amount_out
);
  reg [63:0] regs [0:31];
  integer i;
  // Known contents, so immediate forms never read unknowns
  initial for (i = 0; i < 32; i = i + 1) regs[i] = 64'h0;
  // Writes land at the edge, like a real write-back
  always @(posedge core_clk_in) begin
    if (wr_en_in) begin
      regs[wr_idx_in] <= wr_data_in;
    end
  end
  // Whole registers go out; masking the amount is the unit's job
  assign source_out = regs[instr_in[20:16]];
  assign amount_out = regs[instr_in[25:21]];
endmodule

// ===== verification/srsu_shift_unit_bench.sv
// Self-checking bench for the packed right-shift unit
`timescale 1ns/1ps
`include "srsu_consts.vh"
module srsu_shift_unit_bench;
  localparam [63:0] S = 64'h8001_7fff_c003_fffe;
  reg clk = 0, rst_n = 0, en = 1, iv = 0, ext = 1, wr_en = 0;
  reg [31:0] ins_w = 0;
  reg [4:0] wr_idx = 0;
  reg [63:0] wr_data = 0;
  wire [63:0] src, amt, res;
  wire rv, rexc, dexc;
  integer error_cnt = 0, tests_run = 0, cyc = 0;
  srsu_shift_unit srsu_shift_unit_i (.core_clk_in(clk), .reset_n_in(rst_n), .clk_en_in(en),
    .issue_valid_in(iv), .instr_in(ins_w), .ext_enable_in(ext), .source_register_in(src),
    .shift_amount_register_in(amt), .result_valid_out(rv), .result_out(res),
    .reserved_instr_exc_out(rexc), .ext_disabled_exc_out(dexc));
  srsu_core_model srsu_core_model_i (.core_clk_in(clk), .wr_en_in(wr_en), .wr_idx_in(wr_idx),
    .wr_data_in(wr_data), .instr_in(ins_w), .source_out(src), .amount_out(amt));
  // Clock and hang guard, ceiling far above the few hundred cycles needed
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      error_cnt = error_cnt + 1;
      conclude;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Reference lanes; 33-bit signed temp keeps the rounding add from wrapping
  function automatic [63:0] ex(input [2:0] op, input [63:0] s, input [63:0] a);
    reg [63:0] r;
    reg signed [32:0] t;
    integer i, n;
    begin
      r = 0;
      n = (op == 3) ? a[4:0] : a[3:0];
      for (i = 0; i < 8; i = i + 1) begin
        if (op < 4 && i < 4) begin
          t = (op == 3) ? $signed(s[31:0]) : $signed(s[16*i+:16]);
          t = (op > 1 && n > 0) ? ((t >>> (n - 1)) + 1) >>> 1 : t >>> n;
          r[16*i+:16] = t[15:0];
          if (op == 3) r = {{32{t[31]}}, t[31:0]};
        end
        if (op == 4 || op == 5) r[8*i+:8] = s[8*i+:8] >> a[2:0];
        if (op > 5 && i < 4) r[16*i+:16] = s[16*i+:16] >> a[3:0];
      end
      if (op == 5 || op == 6) r[63:32] = {32{r[31]}};
      ex = r;
    end
  endfunction
  function [31:0] mk(input [4:0] hi, input [4:0] sec, input [5:0] fn);
    mk = {`SRSU_EXT_MAJOR, hi, 5'h02, 5'h03, sec, fn};
  endfunction
  task chk(input string nm, input [63:0] seen, input [63:0] want);
    tests_run = tests_run + 1;
    if (seen !== want) begin
      error_cnt = error_cnt + 1;
      $display("MISMATCH %s expected %h seen %h", nm, want, seen);
    end
  endtask
  // Load amount into r1 and source into r2, issue once, judge flags and data
  task run(input [31:0] i, input [63:0] s, input [63:0] a, input [63:0] e, input [2:0] f);
    wr_en = 1; wr_idx = 1; wr_data = a; @(negedge clk);
    wr_idx = 2; wr_data = s; @(negedge clk);
    wr_en = 0; iv = 1; ins_w = i; @(negedge clk);
    iv = 0;
    chk("flags", {rv, rexc, dexc}, f);
    if (f[2]) chk("result", res, e);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task t_variable;
    integer k;
    reg [63:0] a, w;
    for (k = 0; k < 3; k = k + 1) begin
      a = {60'hfedcba987654321, (k == 2) ? 4'hf : k[3:0]};
      w = {59'h7edcba987654321, (k == 2) ? 5'h1f : k[4:0]};
      run(mk(1, 5'h17, 6'h17), S, a, ex(1, S, a), 3'b100);
      run(mk(1, 5'h1f, 6'h17), S, a, ex(2, S, a), 3'b100);
      run(mk(1, 5'h17, 6'h13), S, w, ex(3, S, w), 3'b100);
    end
  endtask
  task t_logic;
    integer k;
    for (k = 0; k < 16; k = k + 1) begin
      if (k < 8) begin
        run(mk(k[4:0], 5'h01, 6'h17), S, 0, ex(4, S, k), 3'b100);
        run(mk(k[4:0], 5'h01, 6'h13), S, 0, ex(5, S, k), 3'b100);
      end
      run(mk(k[4:0], 5'h19, 6'h13), S, 0, ex(6, S, k), 3'b100);
      run(mk(k[4:0], 5'h19, 6'h17), S, 0, ex(7, S, k), 3'b100);
    end
  endtask
  // Bad encodings, foreign major, extension off, then a gated hold
  task t_refuse;
    run(mk(1, 5'h02, 6'h17), S, 0, 0, 3'b010);
    run(mk(5'h08, 5'h01, 6'h17), S, 0, 0, 3'b010);
    run(mk(5'h10, 5'h19, 6'h13), S, 0, 0, 3'b010);
    run(mk(1, 5'h1f, 6'h13), S, 0, 0, 3'b010);
    run(mk(1, 5'h17, 6'h13) ^ 32'h7c00_0000, S, 0, 0, 3'b000);
    ext = 0;
    run(mk(1, 5'h17, 6'h17), S, 0, 0, 3'b001);
    ext = 1;
    iv = 1; ins_w = mk(1, 5'h17, 6'h17); @(negedge clk);
    iv = 0; en = 0; ins_w = mk(1, 5'h17, 6'h13); repeat (3) @(negedge clk);
    chk("held", res, ex(1, S, 0));
    chk("held_valid", rv, 1);
    en = 1;
  endtask
  task conclude;
    $display("Checks run %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1;
    @(negedge clk);
    chk("reset_flags", {rv, rexc, dexc}, 0);
    chk("reset_res", res, 0);
    t_variable;
    t_logic;
    t_refuse;
    conclude;
  end
endmodule
